// [design/can_mode_and_irq_status_control.sv]
// Purpose: control/status front end of a can controller on apb
// Assumes: protocol engine reports mode-change ack and events as single-cycle pulses
// Notes: mode in force follows the request once the engine acknowledges it
//
// Local design decisions: the register offsets and the APB interface to the registers.
`timescale 1ns/1ns
module can_mode_and_irq_status_control (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // protocol engine side
  input wire logic mode_ack,
  input wire logic [6:0] event_pulse,
  output logic [2:0] mode_request,
  output logic abort_all_tx,
  output logic [2:0] buffer_select,
  output logic [2:0] mode_in_force,
  // interrupt
  output logic irq
);
  // ----------------------------------------
  // registers
  // ----------------------------------------
  logic [7:0] control_ff;
  logic [7:0] nxt_control;
  logic [2:0] mode_ff;
  logic [2:0] nxt_mode;
  logic [6:0] flags_ff;
  logic [6:0] nxt_flags;
  logic [6:0] mask_ff;
  logic [6:0] nxt_mask;
  logic [31:0] prdata_ff;
  logic [31:0] nxt_prdata;
  logic pready_ff;
  logic pslverr_ff;
  logic irq_ff;
  logic [2:0] sel_ff;
  logic [2:0] req_ff;
  logic abort_ff;

  // ----------------------------------------
  // bus decode
  // ----------------------------------------
  wire setup_phase = psel && !penable;
  wire access = psel && penable && pready_ff;
  wire wr = access && pwrite && pstrb[0];
  wire hit_control = (paddr == can_ctrl_pkg::control_addr);
  wire hit_status = (paddr == can_ctrl_pkg::status_addr);
  wire hit_flags = (paddr == can_ctrl_pkg::flags_addr);
  wire hit_mask = (paddr == can_ctrl_pkg::mask_addr);
  wire hit_any = hit_control || hit_status || hit_flags || hit_mask;
  wire bad = !hit_any || (pwrite && hit_status);

  // ----------------------------------------
  // status composition
  // ----------------------------------------
  can_ctrl_pkg::src_code_type src_code;
  can_ctrl_pkg::buf_sel_type buf_sel;
  wire [6:0] pending = flags_ff & mask_ff;
  wire [2:0] req_field = control_ff[can_ctrl_pkg::mode_msb:can_ctrl_pkg::mode_lsb];
  wire [2:0] req_norm = req_field[2] ? can_ctrl_pkg::mode_config : req_field;
  wire [7:0] status_val = {mode_ff, 1'b0, src_code, 1'b0};

  can_irq_encoder u_enc (
    .pending(pending),
    .code(src_code)
  );

  can_window_decode u_win (
    .window(control_ff[can_ctrl_pkg::win_msb:can_ctrl_pkg::win_lsb]),
    .sel(buf_sel)
  );

  // ----------------------------------------
  // next values
  // ----------------------------------------
  always_comb begin
    nxt_control = control_ff;
    if (wr && hit_control) begin
      nxt_control = pwdata[7:0] & can_ctrl_pkg::control_mask;
    end
  end

  // mode in force only ever takes a normalised request, so 101..111 never show
  always_comb begin
    nxt_mode = mode_ff;
    if (mode_ack) begin
      nxt_mode = req_norm;
    end
  end

  // set wins over write-one-to-clear
  always_comb begin
    nxt_flags = flags_ff;
    if (wr && hit_flags) begin
      nxt_flags = flags_ff & ~pwdata[6:0];
    end
    nxt_flags = nxt_flags | event_pulse;
  end

  always_comb begin
    nxt_mask = mask_ff;
    if (wr && hit_mask) begin
      nxt_mask = pwdata[6:0];
    end
  end

  always_comb begin
    nxt_prdata = 32'h00000000;
    if (hit_control) begin
      nxt_prdata = {24'h000000, control_ff};
    end else if (hit_status) begin
      nxt_prdata = {24'h000000, status_val};
    end else if (hit_flags) begin
      nxt_prdata = {25'h0000000, flags_ff};
    end else if (hit_mask) begin
      nxt_prdata = {25'h0000000, mask_ff};
    end
  end

  // ----------------------------------------
  // flip-flops
  // ----------------------------------------
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      control_ff <= can_ctrl_pkg::control_reset;
      mode_ff <= can_ctrl_pkg::mode_config;
      flags_ff <= 7'h00;
      mask_ff <= can_ctrl_pkg::mask_reset;
    end else begin
      control_ff <= nxt_control;
      mode_ff <= nxt_mode;
      flags_ff <= nxt_flags;
      mask_ff <= nxt_mask;
    end
  end

  // no wait states: ready rises in the first access cycle
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= 32'h00000000;
    end else begin
      pready_ff <= setup_phase;
      pslverr_ff <= setup_phase && bad;
      if (setup_phase && !pwrite) begin
        prdata_ff <= nxt_prdata;
      end
    end
  end

  // source code only nonzero while pending, so irq implies nonzero code
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      irq_ff <= 1'b0;
      sel_ff <= can_ctrl_pkg::buf_rx0;
      req_ff <= can_ctrl_pkg::mode_config;
      abort_ff <= 1'b0;
    end else begin
      irq_ff <= |(nxt_flags & nxt_mask);
      sel_ff <= buf_sel;
      req_ff <= req_norm;
      abort_ff <= control_ff[can_ctrl_pkg::abort_bit];
    end
  end

  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign irq = irq_ff;
  assign buffer_select = sel_ff;
  assign mode_request = req_ff;
  assign abort_all_tx = abort_ff;
  assign mode_in_force = mode_ff;
endmodule

// [design/can_ctrl_pkg.sv]
// Purpose: constants and types for the can mode and interrupt status control block
// Assumes: apb slave, 32-bit data, one word per register
// Notes: registers narrower than 32 bits sit in the low bits
// Behaviour
// - mode request with top bit one asks for configuration mode.
// - codes 011, 010, 001, 000 ask listen-only, loopback, disable, normal.
// - abort-all bit aborts pending transmissions in all three transmit buffers.
// - window field selects the buffer mapped into the fast-access area.
// - window 101 rx1; 100,011,010 tx0..tx2; all other codes rx0.
// - mode status field reports mode in force, 100 meaning configuration.
// - source code field shows the highest-priority pending interrupt source.
// - codes 111 wake, 110 rx0, 101 rx1, 100..010 tx0..2, 001 error, 000 none.
// - each buffer's source code equals its window code.
// - while the interrupt is signalled the source code is never 000.
package can_ctrl_pkg;
  localparam logic [11:0] control_addr = 12'h000;
  localparam logic [11:0] status_addr = 12'h004;
  localparam logic [11:0] flags_addr = 12'h008;
  localparam logic [11:0] mask_addr = 12'h00C;
  localparam int mode_msb = 7;
  localparam int mode_lsb = 5;
  localparam int abort_bit = 4;
  localparam int win_msb = 3;
  localparam int win_lsb = 1;
  localparam logic [7:0] control_reset = 8'h80;
  localparam logic [7:0] control_mask = 8'hFE;
  localparam int n_events = 7;
  localparam logic [6:0] mask_reset = 7'h00;
  // event flag positions
  localparam int ev_error = 0;
  localparam int ev_tx2 = 1;
  localparam int ev_tx1 = 2;
  localparam int ev_tx0 = 3;
  localparam int ev_rx1 = 4;
  localparam int ev_rx0 = 5;
  localparam int ev_wake = 6;

  typedef enum logic [2:0] {
    mode_normal = 3'b000,
    mode_disable = 3'b001,
    mode_loopback = 3'b010,
    mode_listen = 3'b011,
    mode_config = 3'b100
  } op_mode_type;

  typedef enum logic [2:0] {
    src_none = 3'b000,
    src_error = 3'b001,
    src_tx2 = 3'b010,
    src_tx1 = 3'b011,
    src_tx0 = 3'b100,
    src_rx1 = 3'b101,
    src_rx0 = 3'b110,
    src_wake = 3'b111
  } src_code_type;

  typedef enum logic [2:0] {
    buf_rx0 = 3'b000,
    buf_rx1 = 3'b001,
    buf_tx0 = 3'b010,
    buf_tx1 = 3'b011,
    buf_tx2 = 3'b100
  } buf_sel_type;

  typedef struct packed {
    logic [2:0] mode_request;
    logic abort_all_tx;
    logic [2:0] buffer_window_select;
  } control_type;
endpackage

// [design/can_irq_encoder.sv]
// Purpose: priority encoder from event flags to source code
// Assumes: flags already masked
// Notes: wake highest, error lowest
`timescale 1ns/1ns
module can_irq_encoder (
  // masked pending flags
  input wire logic [6:0] pending,
  // encoded source
  output can_ctrl_pkg::src_code_type code
);
  always_comb begin
    code = can_ctrl_pkg::src_none;
    if (pending[can_ctrl_pkg::ev_wake]) begin
      code = can_ctrl_pkg::src_wake;
    end else if (pending[can_ctrl_pkg::ev_rx0]) begin
      code = can_ctrl_pkg::src_rx0;
    end else if (pending[can_ctrl_pkg::ev_rx1]) begin
      code = can_ctrl_pkg::src_rx1;
    end else if (pending[can_ctrl_pkg::ev_tx0]) begin
      code = can_ctrl_pkg::src_tx0;
    end else if (pending[can_ctrl_pkg::ev_tx1]) begin
      code = can_ctrl_pkg::src_tx1;
    end else if (pending[can_ctrl_pkg::ev_tx2]) begin
      code = can_ctrl_pkg::src_tx2;
    end else if (pending[can_ctrl_pkg::ev_error]) begin
      code = can_ctrl_pkg::src_error;
    end
  end
endmodule

// [design/can_window_decode.sv]
// Purpose: window code to buffer select
// Assumes: none
// Notes: unlisted codes fall back to receive buffer 0
`timescale 1ns/1ns
module can_window_decode (
  // window code
  input wire logic [2:0] window,
  // selected buffer
  output can_ctrl_pkg::buf_sel_type sel
);
  always_comb begin
    case (window)
      3'b101: sel = can_ctrl_pkg::buf_rx1;
      3'b100: sel = can_ctrl_pkg::buf_tx0;
      3'b011: sel = can_ctrl_pkg::buf_tx1;
      3'b010: sel = can_ctrl_pkg::buf_tx2;
      default: sel = can_ctrl_pkg::buf_rx0;
    endcase
  end
endmodule

// [bench/can_engine_model.sv]
// Purpose: protocol engine stand-in for the control block
// Assumes: one clock, async active high reset
// Notes: acks a pending mode change after lag+1 cycles; events follow fire
`timescale 1ns/1ns
module can_engine_model (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // bench control
  input wire logic [3:0] lag,
  input wire logic [6:0] fire,
  // from design
  input wire logic [2:0] mode_request,
  input wire logic [2:0] mode_in_force,
  // to design
  output logic mode_ack,
  output logic [6:0] event_pulse
);
  logic [3:0] cnt_ff;
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      cnt_ff <= 4'h0;
      mode_ack <= 1'b0;
      event_pulse <= 7'h00;
    end else begin
      event_pulse <= fire;
      mode_ack <= 1'b0;
      cnt_ff <= 4'h0;
      if (mode_request != mode_in_force && !mode_ack) begin
        cnt_ff <= cnt_ff + 4'h1;
        mode_ack <= cnt_ff >= lag;
      end
    end
  end
endmodule

// [bench/can_ctrl_properties.sv]
// Purpose: port-level checks of the control and status block
// Assumes: bound to the top module
// Notes: one clock domain
`timescale 1ns/1ns
module can_ctrl_properties (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  // engine side
  input wire logic mode_ack,
  input wire logic [2:0] mode_request,
  input wire logic abort_all_tx,
  input wire logic [2:0] buffer_select,
  input wire logic [2:0] mode_in_force,
  input wire logic irq
);
  default clocking dc @(posedge core_clk); endclocking
  default disable iff (reset);
  wire done = psel && penable && pready;
  wire wr_ctl = done && pwrite && pstrb[0] && paddr == can_ctrl_pkg::control_addr;
  wire rd_st = done && !pwrite && paddr == can_ctrl_pkg::status_addr;
  chk_req_config: assert property (mode_request[2] |-> mode_request[1:0] == 2'h0)
    else $error("mode request not normalised");
  chk_req_listen: assert property (wr_ctl && pwdata[7:5] == 3'h3 |-> ##[1:2] mode_request == 3'h3)
    else $error("listen request lost");
  chk_mode_follow: assert property (mode_ack |=> mode_in_force == $past(mode_request))
    else $error("mode in force missed the ack");
  chk_mode_hold: assert property (!mode_ack |=> $stable(mode_in_force))
    else $error("mode changed without ack");
  chk_mode_legal: assert property (mode_in_force[2] |-> mode_in_force[1:0] == 2'h0)
    else $error("reserved mode reported");
  chk_abort_set: assert property (wr_ctl && pwdata[4] |-> ##[1:2] abort_all_tx)
    else $error("abort not raised");
  chk_win_rx1: assert property (wr_ctl && pwdata[3:1] == 3'h5 |-> ##[1:2] buffer_select == 3'h1)
    else $error("window rx1 wrong");
  chk_win_rx0: assert property (wr_ctl && (pwdata[3:2] == 2'h3 || pwdata[3:2] == 2'h0)
    |-> ##[1:2] buffer_select == 3'h0)
    else $error("window rx0 wrong");
  chk_irq_code: assert property (rd_st && irq |-> prdata[3:1] != 3'h0)
    else $error("source code none while irq");
  chk_status_pad: assert property (rd_st |-> prdata[31:8] == 24'h0 && !prdata[4] && !prdata[0])
    else $error("status padding not zero");
endmodule

// [bench/can_mode_and_irq_status_control_bench.sv]
// Purpose: self-checking bench of the control and status block
// Assumes: engine model on the far side
// Notes: flags and mask modelled with integers
`timescale 1ns/1ns
module can_mode_and_irq_status_control_bench;
  logic core_clk = 0, reset = 1, psel = 0, penable = 0, pwrite = 0, er;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [3:0] pstrb = 4'hF, lag = 4'h0;
  logic [6:0] fire = 7'h00, event_pulse;
  logic pready, pslverr, mode_ack, abort_all_tx, irq;
  logic [2:0] mode_request, buffer_select, mode_in_force;
  int fails = 0, cmp_count = 0, flags_m, mask_m, e, a;
  localparam logic [11:0] ctl = can_ctrl_pkg::control_addr;
  localparam logic [11:0] sts = can_ctrl_pkg::status_addr;
  localparam logic [11:0] flg = can_ctrl_pkg::flags_addr;
  localparam logic [11:0] msk = can_ctrl_pkg::mask_addr;
  can_mode_and_irq_status_control dut (.core_clk, .reset, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pstrb, .prdata, .pready, .pslverr, .mode_ack, .event_pulse, .mode_request,
    .abort_all_tx, .buffer_select, .mode_in_force, .irq);
  can_engine_model eng (.core_clk, .reset, .lag, .fire, .mode_request, .mode_in_force,
    .mode_ack, .event_pulse);
  initial forever #50 core_clk = ~core_clk;
  task automatic final_report;
    $display("checks %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    while (n < 20) begin
      @(posedge core_clk);
      if (pready === 1'b1) break;
      n++;
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) begin
      fails++;
      final_report();
    end
  endtask
  task automatic settle;
    repeat (2) @(negedge core_clk);
  endtask
  task automatic fire_evt(input int f);
    @(posedge core_clk);
    fire <= 7'(f);
    @(posedge core_clk);
    fire <= 7'h00;
    flags_m |= f;
    settle();
  endtask
  function automatic int top(input int f);
    top = 0;
    for (int i = 0; i < 7; i++) if (f[i]) top = i + 1;
  endfunction
  initial begin
    void'($urandom(32'hE2A5));
    repeat (8) @(posedge core_clk);
    reset <= 1'b0;
    apb(0, ctl, 0);
    check(rd, 32'h80);
    apb(0, sts, 0);
    check(rd, 32'h80);
    // every request code, ending in normal; 001 is disable
    for (int m = 7; m >= 0; m--) begin
      lag <= 4'($urandom % 8);
      apb(1, ctl, 32'(m) << 5);
      e = m > 3 ? 4 : m;
      for (int n = 0; n < 30 && mode_in_force !== 3'(e); n++) @(negedge core_clk);
      if (mode_in_force !== 3'(e)) begin
        fails++;
        final_report();
      end
      check(32'(mode_request), e);
      apb(0, sts, 0);
      check(rd, e << 5);
    end
    $display("mode test done");
    for (int w = 0; w < 8; w++) begin
      a = $urandom % 2;
      apb(1, ctl, (w << 1) | (a << 4));
      settle();
      check(32'(buffer_select), w == 5 ? 1 : (w >= 2 && w <= 4) ? 6 - w : 0);
      check(32'(abort_all_tx), a);
    end
    $display("window test done");
    apb(1, msk, 32'h7F);
    for (int i = 0; i < 7; i++) begin
      fire_evt(1 << i);
      apb(0, sts, 0);
      check(rd, (i + 1) << 1);
      check(32'(irq), 1);
      if (i > 0 && i < 6) begin
        apb(1, ctl, rd & 32'hE);
        settle();
        check(32'(buffer_select), 5 - i);
      end
      apb(1, flg, 1 << i);
      flags_m = 0;
      settle();
      check(32'(irq), 0);
    end
    $display("source test done");
    for (int k = 0; k < 8; k++) begin
      mask_m = $urandom % 128;
      apb(1, msk, mask_m);
      fire_evt($urandom % 128);
      apb(0, sts, 0);
      check(rd, top(flags_m & mask_m) << 1);
      check(32'(irq), (flags_m & mask_m) != 0);
      apb(1, flg, 32'h7F);
      flags_m = 0;
    end
    apb(0, 12'h010, 0);
    check(32'(er), 1);
    $display("priority test done");
    final_report();
  end
endmodule
bind can_mode_and_irq_status_control can_ctrl_properties chk (.core_clk, .reset, .psel,
  .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .mode_ack, .mode_request,
  .abort_all_tx, .buffer_select, .mode_in_force, .irq);
